// >>> adc_seq_pkg.sv
package adc_seq_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_SEQ = 4;
    localparam int RESULT_W = 10;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] OFF_ACTIVE = 12'h000;
    localparam logic [11:0] OFF_RAW_IRQ = 12'h004;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFF_MASKED_IRQ = 12'h00c;
    localparam logic [11:0] OFF_OVERFLOW = 12'h010;
    localparam logic [11:0] OFF_TRIGGER_SEL = 12'h014;
    localparam logic [11:0] OFF_UNDERFLOW = 12'h018;
    localparam logic [11:0] OFF_PRIORITY = 12'h020;
    localparam logic [11:0] OFF_SW_INIT = 12'h028;
    localparam logic [11:0] OFF_AVERAGING = 12'h030;
    localparam logic [11:0] OFF_SEQ_BASE = 12'h040;
    localparam logic [11:0] OFF_SEQ_END = 12'h0c0;
    localparam int SEQ_IDX_LSB = 5;
    localparam logic [4:0] SEQ_INPUT = 5'h00;
    localparam logic [4:0] SEQ_CONTROL = 5'h04;
    localparam logic [4:0] SEQ_FIFO = 5'h08;
    localparam logic [4:0] SEQ_STATUS = 5'h0c;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam logic [15:0] PRIORITY_RESET = 16'h3210;
    localparam logic [15:0] PRIORITY_MASK = 16'h3333;
    localparam int CTL_DIFF = 0;
    localparam int CTL_END = 1;
    localparam int CTL_IE = 2;
    localparam int CTL_TEMP = 3;
    localparam int FST_TAIL_LSB = 0;
    localparam int FST_HEAD_LSB = 4;
    localparam int FST_EMPTY = 8;
    localparam int FST_FULL = 12;
    localparam logic [2:0] AVG_MAX_SHIFT = 3'h6;

    // ****************************************
    // trigger source codes
    // ****************************************
    localparam logic [3:0] TRIG_SOFTWARE = 4'h0;
    localparam logic [3:0] TRIG_COMP0 = 4'h1;
    localparam logic [3:0] TRIG_COMP1 = 4'h2;
    localparam logic [3:0] TRIG_COMP2 = 4'h3;
    localparam logic [3:0] TRIG_GPIO = 4'h4;
    localparam logic [3:0] TRIG_TIMER = 4'h5;
    localparam logic [3:0] TRIG_ALWAYS = 4'hf;

    // ****************************************
    // conversion pacing
    // ****************************************
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int ADC_CLK_HZ = 16_667_000;
    localparam int TICK_DIV_INT = (SYS_CLK_HZ > ADC_CLK_HZ) ? SYS_CLK_HZ / ADC_CLK_HZ : 1;
    localparam logic [7:0] TICK_DIV = 8'(TICK_DIV_INT);

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} seq_state_t;

    typedef struct packed {
        logic start;
        logic [2:0] input_sel;
        logic diff;
        logic temp;
    } conv_req_t;

    typedef struct packed {
        logic done;
        logic [9:0] code;
    } conv_rsp_t;

    typedef struct packed {
        logic [2:0] comp;
        logic gpio;
        logic timer;
    } trig_in_t;

    typedef struct packed {
        seq_state_t fsm;
        logic [1:0] cur;
        logic [2:0] step;
        logic [6:0] avg_cnt;
        logic [15:0] acc;
        logic [7:0] tick_cnt;
        conv_req_t conv;
        logic apb_ack;
        logic [31:0] rd_data;
        logic rd_empty;
        logic [3:0] active, raw, mask, ovf, unf, pending;
        logic [15:0] trig_sel, prio;
        logic [2:0] avg;
        logic [3:0][31:0] in_sel;
        logic [3:0][31:0] ctl;
        logic [3:0][7:0][9:0] mem;
        logic [3:0][2:0] head, tail;
        logic [3:0][3:0] count;
    } state_t;

    // fifo depth and longest sequence of each sequencer
    function automatic logic [3:0] seq_depth(input logic [1:0] idx);
        case (idx)
            2'h0: seq_depth = 4'h8;
            2'h3: seq_depth = 4'h1;
            default: seq_depth = 4'h4;
        endcase
    endfunction

endpackage

// >>> adc_sequencer.sv
// How it works
// - four sequencers, fifo depths eight, four, four, one
// - fifo word is 32 bits, result low ten
// - each step has input and control nibbles
// - runs only when enabled; config always writable
// - same input may repeat within a sequence
// - raw interrupt after any step with enable
// - sequence ends after first step with end
// - fifo is circular; read pops oldest entry
// - status shows head, tail, full and empty
// - overflow and underflow recorded per sequencer
// - conversion pacing derived from clock, targets 16.667 MHz
// - interrupt forwarded only when mask bit set
// - raw status and masked status registers
// - writing one to masked status clears
// - simultaneous triggers served by priority, 0 first
// - trigger source chosen per sequencer
// - software initiate starts software-triggered sequencers
// - always trigger retriggers and may starve others
// - averager averages up to 64 conversions
// - averager off after reset, one shared
// - single-ended codes pass through 0x000 to 0x3ff
// - differential pair k uses inputs 2k, 2k+1
// - differential zero code 0x1ff passes unchanged
// - priority resets to 0x3210
//
// Decided for this implementation: the placing of the registers and register access over APB.
module adc_sequencer
    import adc_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire trig_in_t trig,
    output conv_req_t conv_req,
    input wire conv_rsp_t conv_rsp,
    output logic [3:0] irq
);

    // ****************************************
    // helper functions
    // ****************************************

    // pick the requester with the smallest priority value
    function automatic logic [1:0] pick_seq(input logic [3:0] req, input logic [15:0] prio);
        logic [1:0] best;
        logic [2:0] best_p;
        best = 2'h0;
        best_p = 3'h4;
        for (int i = 0; i < NUM_SEQ; i++) begin
            if (req[i] && ({1'b0, prio[4*i +: 2]} < best_p)) begin
                best = 2'(i);
                best_p = {1'b0, prio[4*i +: 2]};
            end
        end
        return best;
    endfunction

    // does the selected source fire this cycle
    function automatic logic trig_hit(input logic [3:0] sel, input trig_in_t t);
        case (sel)
            TRIG_COMP0: trig_hit = t.comp[0];
            TRIG_COMP1: trig_hit = t.comp[1];
            TRIG_COMP2: trig_hit = t.comp[2];
            TRIG_GPIO: trig_hit = t.gpio;
            TRIG_TIMER: trig_hit = t.timer;
            TRIG_ALWAYS: trig_hit = 1'b1;
            default: trig_hit = 1'b0;
        endcase
    endfunction

    // one nibble of a step register
    function automatic logic [3:0] step_nibble(input logic [31:0] r, input logic [2:0] step);
        return r[4*step +: 4];
    endfunction

    // no requester holds a smaller priority value than the granted one
    function automatic logic grant_ok(input logic [3:0] req, input logic [15:0] prio,
        input logic [1:0] g);
        logic ok;
        ok = req[g];
        for (int i = 0; i < NUM_SEQ; i++) begin
            if (req[i] && (prio[4*i +: 2] < prio[4*g +: 2])) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // ****************************************
    // state and decode
    // ****************************************
    state_t s, n;
    logic tick;
    logic access;
    logic done;
    logic is_seq;
    logic [1:0] sidx;
    logic [4:0] ssub;
    logic [11:0] seq_off;
    logic mapped;
    logic [3:0] push_v;
    logic [3:0] pop_v;
    logic [3:0] raw_set;
    logic [3:0] ovf_set;
    logic [3:0] unf_set;
    logic [3:0] sw_req;
    logic [3:0] hits;
    logic [9:0] push_code;
    logic [3:0] cur_ctl;
    logic step_out;
    logic [15:0] sum;
    logic [6:0] avg_n;
    logic [3:0] cur_in;
    logic [3:0] do_push;

    // address decode of the sequencer blocks
    always_comb begin
        seq_off = paddr - OFF_SEQ_BASE;
        is_seq = (paddr >= OFF_SEQ_BASE) && (paddr < OFF_SEQ_END);
        sidx = seq_off[SEQ_IDX_LSB +: 2];
        ssub = seq_off[4:0];
        case (paddr)
            OFF_ACTIVE, OFF_RAW_IRQ, OFF_IRQ_MASK, OFF_MASKED_IRQ, OFF_OVERFLOW,
            OFF_TRIGGER_SEL, OFF_UNDERFLOW, OFF_PRIORITY, OFF_SW_INIT, OFF_AVERAGING: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = is_seq && (ssub == SEQ_INPUT || ssub == SEQ_CONTROL ||
                    ssub == SEQ_FIFO || ssub == SEQ_STATUS);
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s;
        n.conv.start = 1'b0;
        push_v = '0;
        pop_v = '0;
        raw_set = '0;
        ovf_set = '0;
        unf_set = '0;
        sw_req = '0;
        hits = '0;
        do_push = '0;
        step_out = 1'b0;
        cur_ctl = step_nibble(s.ctl[s.cur], s.step);
        cur_in = step_nibble(s.in_sel[s.cur], s.step);
        sum = s.acc + {6'h00, conv_rsp.code};
        avg_n = 7'h01 << s.avg;
        push_code = 10'(sum >> s.avg);

        // conversion pacing enable
        tick = (s.tick_cnt >= TICK_DIV - 8'h01);
        n.tick_cnt = tick ? 8'h00 : s.tick_cnt + 8'h01;

        // apb: capture in first access cycle, complete in second
        access = psel && penable;
        done = access && s.apb_ack;
        n.apb_ack = access && !s.apb_ack;
        if (access && !s.apb_ack && !pwrite) begin
            n.rd_data = '0;
            n.rd_empty = 1'b0;
            case (paddr)
                OFF_ACTIVE: n.rd_data[3:0] = s.active;
                OFF_RAW_IRQ: n.rd_data[3:0] = s.raw;
                OFF_IRQ_MASK: n.rd_data[3:0] = s.mask;
                OFF_MASKED_IRQ: n.rd_data[3:0] = s.raw & s.mask;
                OFF_OVERFLOW: n.rd_data[3:0] = s.ovf;
                OFF_TRIGGER_SEL: n.rd_data[15:0] = s.trig_sel;
                OFF_UNDERFLOW: n.rd_data[3:0] = s.unf;
                OFF_PRIORITY: n.rd_data[15:0] = s.prio;
                OFF_AVERAGING: n.rd_data[2:0] = s.avg;
                default: begin
                    if (is_seq) begin
                        case (ssub)
                            SEQ_INPUT: n.rd_data = s.in_sel[sidx];
                            SEQ_CONTROL: n.rd_data = s.ctl[sidx];
                            SEQ_FIFO: begin
                                n.rd_empty = (s.count[sidx] == 4'h0);
                                if (s.count[sidx] != 4'h0) begin
                                    n.rd_data[9:0] = s.mem[sidx][s.head[sidx]];
                                end
                            end
                            SEQ_STATUS: begin
                                n.rd_data[FST_TAIL_LSB +: 3] = s.tail[sidx];
                                n.rd_data[FST_HEAD_LSB +: 3] = s.head[sidx];
                                n.rd_data[FST_EMPTY] = (s.count[sidx] == 4'h0);
                                n.rd_data[FST_FULL] = (s.count[sidx] == seq_depth(sidx));
                            end
                            default: n.rd_data = '0;
                        endcase
                    end
                end
            endcase
        end

        // register writes and read side effects at completion
        if (done && pwrite) begin
            case (paddr)
                OFF_ACTIVE: n.active = pwdata[3:0];
                OFF_IRQ_MASK: n.mask = pwdata[3:0];
                OFF_MASKED_IRQ: n.raw = s.raw & ~pwdata[3:0];
                OFF_OVERFLOW: n.ovf = s.ovf & ~pwdata[3:0];
                OFF_TRIGGER_SEL: n.trig_sel = pwdata[15:0];
                OFF_UNDERFLOW: n.unf = s.unf & ~pwdata[3:0];
                OFF_PRIORITY: n.prio = pwdata[15:0] & PRIORITY_MASK;
                OFF_AVERAGING: begin
                    n.avg = (pwdata[2:0] > AVG_MAX_SHIFT) ? AVG_MAX_SHIFT : pwdata[2:0];
                end
                OFF_SW_INIT: begin
                    for (int i = 0; i < NUM_SEQ; i++) begin
                        sw_req[i] = pwdata[i] && (s.trig_sel[4*i +: 4] == TRIG_SOFTWARE);
                    end
                end
                default: begin
                    if (is_seq && ssub == SEQ_INPUT) begin
                        n.in_sel[sidx] = pwdata;
                    end
                    if (is_seq && ssub == SEQ_CONTROL) begin
                        n.ctl[sidx] = pwdata;
                    end
                end
            endcase
        end
        if (done && !pwrite && is_seq && ssub == SEQ_FIFO) begin
            pop_v[sidx] = !s.rd_empty;
            unf_set[sidx] = s.rd_empty;
        end

        // sequencer: one conversion in flight at a time
        case (s.fsm)
            ST_IDLE: begin
                if (|(s.active & s.pending)) begin
                    n.cur = pick_seq(s.active & s.pending, s.prio);
                    n.pending[n.cur] = 1'b0;
                    n.step = 3'h0;
                    n.avg_cnt = '0;
                    n.acc = '0;
                    n.fsm = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (!s.active[s.cur]) begin
                    n.fsm = ST_IDLE;
                end else if (tick) begin
                    n.conv.start = 1'b1;
                    n.conv.diff = cur_ctl[CTL_DIFF];
                    n.conv.temp = cur_ctl[CTL_TEMP];
                    if (cur_ctl[CTL_DIFF]) begin
                        n.conv.input_sel = {cur_in[1:0], 1'b0};
                    end else begin
                        n.conv.input_sel = cur_in[2:0];
                    end
                    n.fsm = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (conv_rsp.done) begin
                    if (s.avg_cnt + 7'h01 >= avg_n) begin
                        step_out = 1'b1;
                        push_v[s.cur] = 1'b1;
                        raw_set[s.cur] = cur_ctl[CTL_IE];
                        n.avg_cnt = '0;
                        n.acc = '0;
                        if (cur_ctl[CTL_END] || ({1'b0, s.step} == seq_depth(s.cur) - 4'h1)) begin
                            n.fsm = ST_IDLE;
                        end else begin
                            n.step = s.step + 3'h1;
                            n.fsm = ST_ISSUE;
                        end
                    end else begin
                        n.avg_cnt = s.avg_cnt + 7'h01;
                        n.acc = sum;
                        n.fsm = ST_ISSUE;
                    end
                end
            end
            default: n.fsm = ST_IDLE;
        endcase

        // circular fifos, overflow drops the new word
        for (int i = 0; i < NUM_SEQ; i++) begin
            do_push[i] = push_v[i] && (s.count[i] != seq_depth(2'(i)));
            ovf_set[i] = push_v[i] && !do_push[i];
            if (do_push[i]) begin
                n.mem[i][s.tail[i]] = push_code;
                n.tail[i] = (4'(s.tail[i]) == seq_depth(2'(i)) - 4'h1) ? 3'h0 : s.tail[i] + 3'h1;
            end
            if (pop_v[i]) begin
                n.head[i] = (4'(s.head[i]) == seq_depth(2'(i)) - 4'h1) ? 3'h0 : s.head[i] + 3'h1;
            end
            n.count[i] = s.count[i] + 4'(do_push[i]) - 4'(pop_v[i]);
            hits[i] = trig_hit(s.trig_sel[4*i +: 4], trig);
        end

        // events last so that a set beats a same-cycle clear
        n.raw = n.raw | raw_set;
        n.ovf = n.ovf | ovf_set;
        n.unf = n.unf | unf_set;
        n.pending = n.pending | hits | sw_req;
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.prio <= PRIORITY_RESET;
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = s.rd_data;
    assign pready = done;
    assign pslverr = done && !mapped;
    assign conv_req = s.conv;
    assign irq = s.raw & s.mask;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_single_conv: assert property (conv_req.start |=> s.fsm == ST_WAIT && !conv_req.start)
        else $error("conversion started while one in flight");
    // grant check is independent of the arbiter's own search
    a_grant_order: assert property (s.fsm == ST_IDLE && |(s.active & s.pending)
        |-> grant_ok(s.active & s.pending, s.prio, n.cur))
        else $error("grant ignored priority");
    a_end_stops: assert property (step_out && cur_ctl[CTL_END] |=> s.fsm == ST_IDLE)
        else $error("sequence ran past end step");
    a_ie_raises: assert property (step_out && cur_ctl[CTL_IE] |=> s.raw[$past(s.cur)])
        else $error("step interrupt not raised");
    a_full_overflow: assert property (push_v[0] && s.count[0] == 4'h8 |=> s.ovf[0])
        else $error("overflow not recorded");
    a_raw_sets: assert property (|raw_set |=> (s.raw & $past(raw_set)) == $past(raw_set))
        else $error("raw status not set by step event");
    a_disabled_idle: assert property (s.fsm == ST_IDLE && s.active == 4'h0
        |=> s.fsm == ST_IDLE)
        else $error("disabled sequencer started");
    a_diff_even: assert property (conv_req.start && conv_req.diff
        |-> !conv_req.input_sel[0])
        else $error("differential pair not even");
    a_apb_wait: assert property (psel && penable && !pready |=> !psel || pready)
        else $error("apb answer late");

    c_always_run: cover property (s.fsm == ST_IDLE && s.trig_sel[3:0] == TRIG_ALWAYS ##1
        s.fsm == ST_ISSUE);
    c_overflow: cover property (|ovf_set);
    c_average: cover property (step_out && s.avg == AVG_MAX_SHIFT);
    c_fifo_pop: cover property (|pop_v);
    c_diff_step: cover property (conv_req.start && conv_req.diff);

endmodule

// >>> adc_core_model.sv
module adc_core_model
    import adc_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire conv_req_t conv_req,
    input wire logic [3:0] delay,
    output conv_rsp_t conv_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy;
    logic [3:0] left;
    logic [9:0] code;

    // ********************************
    // converter core
    // ********************************
    // one conversion in flight, answered after a programmable wait
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            left <= 4'h0;
            code <= 10'h000;
            conv_rsp <= '0;
        end else begin
            if (conv_req.start) begin
                busy <= 1'b1;
                left <= delay;
                // temperature fixed, pairs held at zero difference, else by input
                code <= conv_req.temp ? 10'h2aa : conv_req.diff ? 10'h1ff :
                    {conv_req.input_sel, 7'h4b};
                conv_rsp.done <= 1'b0;
            end else if (busy && left == 4'h0) begin
                busy <= 1'b0;
                conv_rsp <= '{done: 1'b1, code: code};
            end else begin
                // code toggles between answers so a stale value is never valid
                left <= left - 4'(busy);
                conv_rsp <= '{done: 1'b0, code: ~conv_rsp.code};
            end
        end
    end
endmodule

// >>> adc_sample_sequencer_control_test.sv
module adc_sample_sequencer_control_test
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h5559c9ee;
    logic pready, pslverr, last_err;
    trig_in_t trig = '0;
    conv_req_t conv_req;
    conv_rsp_t conv_rsp;
    logic [3:0] irq;
    logic [3:0] delay = 4'h2;
    int mismatches = 0, checks_done = 0, starts = 0, dones = 0;
    conv_req_t seen_q[$];
    logic [3:0] codes[5] = '{TRIG_COMP0, TRIG_COMP1, TRIG_COMP2, TRIG_GPIO, TRIG_TIMER};
    logic [4:0] srcs[5] = '{5'h04, 5'h08, 5'h10, 5'h02, 5'h01};

    adc_sequencer adc_sequencer_i (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig(trig),
        .conv_req(conv_req), .conv_rsp(conv_rsp), .irq(irq));
    adc_core_model adc_core_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .conv_req(conv_req), .delay(delay), .conv_rsp(conv_rsp));

    // ********************************
    // clock, monitor and helpers
    // ********************************
    always #50 sys_clk = ~sys_clk;

    // log each request and count answers
    always @(posedge sys_clk) begin
        if (conv_req.start === 1'b1) begin
            check(32'(starts - dones), 32'h0, "start while busy");
            starts++;
            seen_q.push_back(conv_req);
        end
        if (conv_rsp.done === 1'b1) dones++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_code(input conv_req_t r);
        if (r.temp) return 32'h2aa;
        if (r.diff) return 32'h1ff;
        return {22'h0, r.input_sel, 7'h4b};
    endfunction

    function automatic logic [11:0] sa(input int n, input logic [4:0] o);
        return OFF_SEQ_BASE + 12'(n * 32) + 12'(o);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string what);
        apb(1'b0, a, 32'h0);
        check(q, e, what);
    endtask

    task automatic wait_dones(input int n);
        int t;
        t = 0;
        while (dones < n && t < 2000) begin
            @(posedge sys_clk);
            t++;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ********************************
    // tests
    // ********************************
    initial begin
        repeat (30000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] in_w;
        int base;
        int shifts[2] = '{2, 7};
        int counts[2] = '{4, 64};
        conv_req_t r;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(OFF_PRIORITY, 32'h3210, "priority reset");
        rd_chk(OFF_AVERAGING, 32'h0, "averager off");
        rd_chk(sa(0, SEQ_STATUS), 32'h100, "fifo empty");
        rd_chk(12'h024, 32'h0, "unmapped read");
        check(32'(last_err), 32'h1, "unmapped error");
        $display("test reset done");
        // random inputs, step 1 repeats step 0, step 2 is a pair
        in_w = rnd() & 32'h77777777;
        in_w[7:4] = in_w[3:0];
        in_w[10] = 1'b0;
        wr(sa(0, SEQ_INPUT), in_w);
        wr(sa(0, SEQ_CONTROL), 32'h0206_8140);
        wr(OFF_ACTIVE, 32'h1);
        delay <= 4'(rnd() & 32'h7);
        base = dones;
        wr(OFF_SW_INIT, 32'h1);
        wait_dones(base + 5);
        check(32'(dones - base), 32'h5, "steps before end");
        apb(1'b0, sa(0, SEQ_STATUS), 32'h0);
        check(32'(q[6:4] ^ q[2:0]) | (q & 32'h1100), 32'h5, "five queued");
        for (int i = 0; i < 5; i++) begin
            r = seen_q.pop_front();
            check(32'(r), 32'({1'b1, (i == 2) ? {in_w[9:8], 1'b0} : in_w[i*4 +: 3],
                i == 2, i == 3}), "step request");
            rd_chk(sa(0, SEQ_FIFO), exp_code(r), "fifo order");
        end
        rd_chk(sa(0, SEQ_FIFO), 32'h0, "empty pop");
        rd_chk(OFF_UNDERFLOW, 32'h1, "underflow");
        apb(1'b0, sa(0, SEQ_STATUS), 32'h0);
        check(32'(q[6:4] ^ q[2:0]) | (q & 32'h1100), 32'h100, "drained");
        rd_chk(OFF_RAW_IRQ, 32'h1, "raw irq");
        check(32'(irq), 32'h0, "irq masked");
        wr(OFF_IRQ_MASK, 32'h1);
        @(negedge sys_clk);
        check(32'(irq), 32'h1, "irq forwarded");
        rd_chk(OFF_MASKED_IRQ, 32'h1, "masked status");
        wr(OFF_MASKED_IRQ, 32'h0);
        rd_chk(OFF_RAW_IRQ, 32'h1, "zero write");
        wr(OFF_MASKED_IRQ, 32'h1);
        rd_chk(OFF_RAW_IRQ, 32'h0, "cleared");
        $display("test sequence done");
        wr(sa(3, SEQ_CONTROL), 32'h2);
        wr(OFF_ACTIVE, 32'h8);
        for (int k = 0; k < 5; k++) begin
            wr(sa(3, SEQ_INPUT), 32'(k));
            wr(OFF_TRIGGER_SEL, 32'({codes[k], 12'h000}));
            base = dones;
            trig <= trig_in_t'(srcs[k]);
            @(posedge sys_clk);
            trig <= '0;
            wait_dones(base + 1);
            rd_chk(sa(3, SEQ_FIFO), 32'({k[2:0], 7'h4b}), "trigger source");
        end
        wr(OFF_TRIGGER_SEL, 32'h0);
        for (int j = 0; j < 2; j++) begin
            wr(sa(3, SEQ_INPUT), 32'(j));
            base = dones;
            wr(OFF_SW_INIT, 32'h8);
            wait_dones(base + 1);
        end
        rd_chk(OFF_OVERFLOW, 32'h8, "overflow");
        apb(1'b0, sa(3, SEQ_STATUS), 32'h0);
        check(q & 32'h1100, 32'h1000, "depth one full");
        wr(OFF_OVERFLOW, 32'h8);
        rd_chk(OFF_OVERFLOW, 32'h0, "overflow cleared");
        rd_chk(sa(3, SEQ_FIFO), 32'h04b, "first word kept");
        foreach (shifts[j]) begin
            wr(OFF_AVERAGING, 32'(shifts[j]));
            base = dones;
            wr(OFF_SW_INIT, 32'h8);
            wait_dones(base + counts[j]);
            check(32'(dones - base), 32'(counts[j]), "averaged count");
            rd_chk(sa(3, SEQ_FIFO), 32'h0cb, "averaged word");
        end
        wr(OFF_AVERAGING, 32'h0);
        $display("test triggers done");
        wr(OFF_PRIORITY, 32'h3012);
        wr(sa(1, SEQ_INPUT), 32'h5);
        wr(sa(1, SEQ_CONTROL), 32'h2);
        wr(sa(2, SEQ_INPUT), 32'h6);
        wr(sa(2, SEQ_CONTROL), 32'h2);
        wr(OFF_ACTIVE, 32'h6);
        seen_q.delete();
        base = dones;
        wr(OFF_SW_INIT, 32'h6);
        wait_dones(base + 2);
        check(32'(seen_q[0].input_sel), 32'h6, "priority first");
        check(32'(seen_q[1].input_sel), 32'h5, "priority second");
        wr(OFF_ACTIVE, 32'h4);
        wr(sa(1, SEQ_INPUT), 32'h7);
        rd_chk(sa(1, SEQ_INPUT), 32'h7, "config while off");
        base = starts;
        wr(OFF_SW_INIT, 32'h2);
        repeat (8) @(posedge sys_clk);
        check(32'(starts - base), 32'h0, "disabled idle");
        wr(OFF_PRIORITY, 32'h3210);
        wr(OFF_TRIGGER_SEL, 32'h000f);
        wr(OFF_ACTIVE, 32'h9);
        wr(OFF_SW_INIT, 32'h8);
        repeat (100) @(posedge sys_clk);
        apb(1'b0, sa(3, SEQ_STATUS), 32'h0);
        check(q & 32'h100, 32'h100, "starved");
        wr(OFF_ACTIVE, 32'h8);
        base = dones;
        wait_dones(base + 2);
        apb(1'b0, sa(3, SEQ_STATUS), 32'h0);
        check(q & 32'h100, 32'h0, "served after");
        $display("test priority done");
        tally_and_finish();
    end
endmodule
